/* File: pkg/wst_pkg.sv */
// Purpose: Constants for the sleep timer control block.
// Assumes: Registers sit at their byte offsets on the internal port.
// Notes: Sleep duration field has no reset value on purpose.
package wst_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [15:0] RC_OFFS = 16'h4000;
  localparam logic [15:0] SCR_OFFS = 16'h4004;
  localparam logic [15:0] PEND_OFFS = 16'h4008;

  // ==========================================================
  // Sleep control fields
  localparam int DUR_LSB = 0;
  localparam int DUR_W = 16;
  localparam int MODE_LSB = 16;
  localparam int TIMING_BIT = 18;
  localparam int WRPOL_BIT = 19;
  localparam int ADHOC_BIT = 20;
  localparam int STATEN_BIT = 21;
  localparam int SCR_CTL_W = 6;

  // ==========================================================
  // Reset control fields
  localparam int RC_MAC_BIT = 0;
  localparam int RC_BB_BIT = 1;
  localparam int RC_CORE_BIT = 4;

  // ==========================================================
  // Reset values and timing
  localparam logic [5:0] SCR_CTL_RST = 6'h01;
  localparam logic [1:0] RC_WARM_RST = 2'h3;
  localparam int CORE_CLR_CYC = 64;
  localparam int BLOCK_TICKS = 4096;

  typedef enum logic [1:0] {
    WST_FORCE_WAKE = 2'b00,
    WST_FORCE_SLEEP = 2'b01,
    WST_AUTO = 2'b10,
    WST_RESERVED = 2'b11
  } wst_mode_t;

endpackage : wst_pkg

/* File: verilog/wst_sleep_ctrl.sv */
// Purpose: Sleep duration timer and sleep control registers.
// Assumes: Register port, tick and tbtt inputs are on core_clk_i.
// Notes: Read data is returned one cycle after reg_rd_i.
`timescale 1ns/1ps

module wst_sleep_ctrl #(
  parameter int NUM_PERF = 4,
  parameter int BLOCK_LEN = wst_pkg::BLOCK_TICKS
) (
  // Clock and reset
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic warm_rst_i,
  // Register port
  input wire logic [15:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [31:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [31:0] reg_rdata_o,
  // Sleep timing
  input wire logic sleep_tick_i,
  input wire logic tbtt_i,
  output logic sleep_en_o,
  output logic dur_expired_o,
  output logic policy_adhoc_o,
  // Statistics and interrupt line
  input wire logic [NUM_PERF-1:0] perf_msb_i,
  output logic stat_irq_o,
  input wire logic inta_active_i,
  // Resets driven out
  output logic core_warm_rst_o,
  output logic mac_warm_rst_o,
  output logic bb_warm_rst_o
);

  localparam int PW = $clog2(BLOCK_LEN);
  localparam logic [PW-1:0] PRE_LAST = PW'(BLOCK_LEN - 1);
  localparam logic [5:0] CLR_LAST = 6'(wst_pkg::CORE_CLR_CYC - 1);

  logic [15:0] dur_q;
  logic [5:0] ctl_q;
  logic [1:0] rc_q;
  logic core_q;
  logic [5:0] clr_cnt_q;
  logic [15:0] cnt_q;
  logic [PW-1:0] pre_q;
  logic pend_q;
  logic sleep_q;
  logic [NUM_PERF-1:0] msb_q;
  logic stat_q;
  logic [31:0] rdata_q;
  logic scr_wr;
  logic rc_wr;
  logic scr_warm;
  logic expired;
  logic awake;
  logic tbtt_load;
  logic block_end;
  wst_pkg::wst_mode_t mode;

  assign scr_wr = reg_wr_i && (reg_addr_i == wst_pkg::SCR_OFFS);
  assign rc_wr = reg_wr_i && (reg_addr_i == wst_pkg::RC_OFFS);
  assign scr_warm = warm_rst_i && core_q;
  assign mode = wst_pkg::wst_mode_t'(ctl_q[1:0]);
  assign expired = (cnt_q == 16'h0000);
  assign awake = !sleep_q;
  assign block_end = sleep_tick_i && (pre_q == PRE_LAST);
  assign tbtt_load = tbtt_i && awake &&
                     (!ctl_q[wst_pkg::TIMING_BIT - 16] || expired);

  // ==========================================================
  // Sleep control register
  // Duration deliberately skips reset; software must load it
  always_ff @(posedge core_clk_i) begin
    if (scr_wr) begin
      dur_q <= reg_wdata_i[15:0];
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || scr_warm) begin
      ctl_q <= wst_pkg::SCR_CTL_RST;
    end else if (scr_wr) begin
      ctl_q <= reg_wdata_i[21:16];
    end
  end

  // ==========================================================
  // Reset control register
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || warm_rst_i) begin
      rc_q <= wst_pkg::RC_WARM_RST;
    end else if (rc_wr) begin
      rc_q <= {reg_wdata_i[wst_pkg::RC_BB_BIT],
               reg_wdata_i[wst_pkg::RC_MAC_BIT]};
    end
  end

  // Auto-clear wins over a repeated write while counting
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      core_q <= 1'b0;
      clr_cnt_q <= 6'h00;
    end else if (core_q) begin
      clr_cnt_q <= clr_cnt_q + 6'h01;
      if (clr_cnt_q == CLR_LAST) begin
        core_q <= 1'b0;
        clr_cnt_q <= 6'h00;
      end
    end else if (rc_wr && reg_wdata_i[wst_pkg::RC_CORE_BIT]) begin
      core_q <= 1'b1;
    end
  end

  // ==========================================================
  // Sleep counter
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      cnt_q <= 16'h0000;
      pre_q <= '0;
    end else if (scr_wr) begin
      pre_q <= '0;
      if (reg_wdata_i[wst_pkg::WRPOL_BIT]) begin
        cnt_q <= 16'h0000;
      end else begin
        cnt_q <= reg_wdata_i[15:0];
      end
    end else if (tbtt_load) begin
      pre_q <= '0;
      cnt_q <= dur_q;
    end else if (sleep_tick_i && !expired) begin
      pre_q <= (pre_q == PRE_LAST) ? '0 : pre_q + PW'(1);
      if (block_end) begin
        cnt_q <= cnt_q - 16'h0001;
      end
    end
  end

  // Reserved mode code keeps the chip awake, the safe side
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      sleep_q <= 1'b1;
    end else begin
      unique case (mode)
        wst_pkg::WST_FORCE_WAKE: sleep_q <= 1'b0;
        wst_pkg::WST_FORCE_SLEEP: sleep_q <= 1'b1;
        wst_pkg::WST_AUTO: sleep_q <= !expired;
        wst_pkg::WST_RESERVED: sleep_q <= 1'b0;
      endcase
    end
  end

  // ==========================================================
  // Statistics interrupt and pending mirror
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      msb_q <= '0;
      stat_q <= 1'b0;
    end else begin
      msb_q <= perf_msb_i;
      stat_q <= ctl_q[wst_pkg::STATEN_BIT - 16] &&
                (|(perf_msb_i & ~msb_q));
    end
  end

  // Line release follows the status reads elsewhere; bit only mirrors
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i || warm_rst_i) begin
      pend_q <= 1'b0;
    end else begin
      pend_q <= inta_active_i;
    end
  end

  // ==========================================================
  // Read data
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      rdata_q <= 32'h0000_0000;
    end else if (reg_rd_i) begin
      unique case (reg_addr_i)
        wst_pkg::RC_OFFS: rdata_q <= {27'h000_0000, core_q, 2'b00, rc_q};
        wst_pkg::SCR_OFFS: rdata_q <= {10'h000, ctl_q, dur_q};
        wst_pkg::PEND_OFFS: rdata_q <= {31'h0000_0000, pend_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  assign reg_rdata_o = rdata_q;
  assign sleep_en_o = sleep_q;
  assign dur_expired_o = expired;
  assign policy_adhoc_o = ctl_q[wst_pkg::ADHOC_BIT - 16];
  assign stat_irq_o = stat_q;
  assign core_warm_rst_o = core_q;
  assign mac_warm_rst_o = rc_q[0];
  assign bb_warm_rst_o = rc_q[1];

  // ==========================================================
  // Checks
  sequence s_core_set;
    $rose(core_q);
  endsequence

  sequence s_core_hold;
    ##63 core_q ##1 !core_q;
  endsequence

  chk_block_count: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (!scr_wr && !tbtt_load && !block_end) |=> $stable(cnt_q))
    else $error("sleep counter moved inside a block");

  chk_auto_sleep: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (mode == wst_pkg::WST_AUTO) |=> (sleep_en_o == !$past(expired)))
    else $error("auto sleep does not follow expiry");

  chk_force_mode: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (ctl_q[1:0] == 2'b01) |=> sleep_en_o)
    else $error("forced sleep not asserted");

  chk_force_wake: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (mode == wst_pkg::WST_FORCE_WAKE) |=> !sleep_en_o)
    else $error("forced wake not asserted");

  chk_reset_sleep: assert property (@(posedge core_clk_i)
    !resetn_i |=> (ctl_q[1:0] == 2'b01) && sleep_en_o)
    else $error("sleep mode not forced after reset");

  chk_tbtt_reload: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (tbtt_i && awake && !scr_wr && ctl_q[2] && !expired && !block_end)
      |=> $stable(cnt_q) && ((pre_q != '0) || ($past(pre_q) == '0)))
    else $error("unexpired counter reloaded at beacon");

  chk_write_load: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    scr_wr |=> (cnt_q == ($past(reg_wdata_i[19]) ? 16'h0000 :
                          $past(reg_wdata_i[15:0]))))
    else $error("counter not loaded by control write");

  chk_stat_gate: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    stat_irq_o |-> $past(ctl_q[5]))
    else $error("statistics interrupt while disabled");

  chk_warm_keep: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    (warm_rst_i && !core_q && !scr_wr) |=> $stable(ctl_q))
    else $error("control lost on warm reset without core bit");

  chk_core_clear: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    s_core_set |-> s_core_hold)
    else $error("core reset bit not cleared after 64 clocks");

  chk_pend_mirror: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    !$past(warm_rst_i) |-> (reg_rdata_o[0] == $past(pend_q)) ||
                           !$past(reg_rd_i) ||
                           ($past(reg_addr_i) != wst_pkg::PEND_OFFS))
    else $error("pending bit read disagrees with line state");

  chk_pend_follow: assert property (@(posedge core_clk_i)
    disable iff (!resetn_i)
    $past(resetn_i) |->
      (pend_q == ($past(inta_active_i) && !$past(warm_rst_i))))
    else $error("pending bit does not follow line drive");

endmodule : wst_sleep_ctrl

/* File: sim/tb_wlan_sleep_timer_control.sv */
// Purpose: Self-checking bench for the sleep timer control block.
// Assumes: Inputs change on falling edges; short block length.
// Notes: Duration field masked out of every read before it is written.
`timescale 1ns/1ps
module tb_wlan_sleep_timer_control;
  localparam int BL = 8;
  localparam logic [15:0] RC = wst_pkg::RC_OFFS;
  localparam logic [15:0] SCR = wst_pkg::SCR_OFFS;
  localparam logic [15:0] PND = wst_pkg::PEND_OFFS;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic warm_rst_i = 1'b0;
  logic [15:0] reg_addr_i = 16'h0000;
  logic reg_wr_i = 1'b0;
  logic [31:0] reg_wdata_i = 32'h0000_0000;
  logic reg_rd_i = 1'b0;
  logic [31:0] reg_rdata_o;
  logic sleep_tick_i = 1'b0;
  logic tbtt_i = 1'b0;
  logic [3:0] perf_msb_i = 4'h0;
  logic inta_active_i = 1'b0;
  logic sleep_en_o, dur_expired_o, policy_adhoc_o, stat_irq_o;
  logic core_warm_rst_o, mac_warm_rst_o, bb_warm_rst_o;
  logic [31:0] seed = 32'h4d71_5d53;
  int fails = 0;
  int total_checks = 0;
  int n;

  wst_sleep_ctrl #(.NUM_PERF(4), .BLOCK_LEN(BL)) DUT (
    .core_clk_i(core_clk_i), .resetn_i(resetn_i), .warm_rst_i(warm_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .sleep_tick_i(sleep_tick_i),
    .tbtt_i(tbtt_i), .sleep_en_o(sleep_en_o),
    .dur_expired_o(dur_expired_o), .policy_adhoc_o(policy_adhoc_o),
    .perf_msb_i(perf_msb_i), .stat_irq_o(stat_irq_o),
    .inta_active_i(inta_active_i), .core_warm_rst_o(core_warm_rst_o),
    .mac_warm_rst_o(mac_warm_rst_o), .bb_warm_rst_o(bb_warm_rst_o));

  always #10 core_clk_i = ~core_clk_i;

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  function automatic logic [31:0] scr(input logic [15:0] d,
                                      input logic [5:0] c);
    scr = {10'h000, c, d};
  endfunction : scr
  // Reserved mode counts as wake
  function automatic logic want_sleep(input logic [1:0] m, input logic e);
    want_sleep = (m == 2'h1) || (m == 2'h2 && !e);
  endfunction : want_sleep

  // ==========================================================
  // Bus and compare tasks
  task automatic chk(input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : chk
  task automatic wr(input logic [15:0] a, input logic [31:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge core_clk_i);
    reg_wr_i = 1'b0;
    @(negedge core_clk_i);
  endtask : wr
  task automatic rdc(input logic [15:0] a, input logic [31:0] e,
                     input logic [31:0] m = 32'hffff_ffff);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge core_clk_i);
    reg_rd_i = 1'b0;
    @(negedge core_clk_i);
    chk(e, reg_rdata_o & m);
  endtask : rdc
  task automatic ticks(input int k);
    repeat (k) begin
      sleep_tick_i = 1'b1;
      @(negedge core_clk_i);
      sleep_tick_i = 1'b0;
      @(negedge core_clk_i);
    end
  endtask : ticks
  task automatic pulse_tbtt;
    tbtt_i = 1'b1;
    @(negedge core_clk_i);
    tbtt_i = 1'b0;
    @(negedge core_clk_i);
  endtask : pulse_tbtt
  task automatic msb_rise(input logic [1:0] i, input int e);
    int c;
    c = 0;
    perf_msb_i[i] = 1'b1;
    repeat (3) begin
      @(negedge core_clk_i);
      c += (stat_irq_o === 1'b1);
    end
    perf_msb_i = 4'h0;
    @(negedge core_clk_i);
    chk(e, c);
  endtask : msb_rise
  task automatic complete_run;
    $display("checks=%0d mismatches=%0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : complete_run

  // Bound well above the under two hundred cycles of the sequence
  initial begin
    #(20 * 20000);
    fails++;
    complete_run();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(negedge core_clk_i);
    resetn_i = 1'b1;
    chk(1'h1, sleep_en_o);
    chk(1'h1, dur_expired_o);
    chk(1'h0, policy_adhoc_o);
    chk(1'h1, mac_warm_rst_o);
    chk(1'h1, bb_warm_rst_o);
    chk(1'h0, core_warm_rst_o);
    rdc(SCR, 32'h0001_0000, 32'hffff_0000);
    rdc(RC, 32'h0000_0003);
    rdc(PND, 32'h0000_0000);
    rdc(16'h4010, 32'h0000_0000);
    for (int m = 0; m < 4; m++) begin
      seed = lfsr(seed);
      wr(SCR, scr(seed[15:0] | 16'h0001, {4'h0, m[1:0]}));
      @(negedge core_clk_i);
      chk(want_sleep(m[1:0], 1'b0), sleep_en_o);
      rdc(SCR, scr(seed[15:0] | 16'h0001, {4'h0, m[1:0]}));
    end
    wr(SCR, scr(16'h0002, 6'h02));
    ticks(2 * BL - 1);
    chk(1'h0, dur_expired_o);
    ticks(1);
    chk(1'h1, dur_expired_o);
    @(negedge core_clk_i);
    chk(want_sleep(2'h2, 1'b1), sleep_en_o);
    wr(SCR, scr(16'h0003, 6'h08));
    chk(1'h1, dur_expired_o);
    pulse_tbtt();
    chk(1'h0, dur_expired_o);
    wr(SCR, scr(16'h0001, 6'h04));
    ticks(BL / 2);
    pulse_tbtt();
    ticks(BL / 2);
    chk(1'h1, dur_expired_o);
    pulse_tbtt();
    chk(1'h0, dur_expired_o);
    wr(SCR, scr(16'h0003, 6'h09));
    pulse_tbtt();
    chk(1'h1, dur_expired_o);
    wr(SCR, scr(16'h0000, 6'h10));
    chk(1'h1, policy_adhoc_o);
    seed = lfsr(seed);
    msb_rise(seed[1:0], 0);
    wr(SCR, scr(16'h0000, 6'h20));
    msb_rise(seed[3:2], 1);
    inta_active_i = 1'b1;
    wr(PND, 32'h0000_0000);
    rdc(PND, 32'h0000_0001);
    inta_active_i = 1'b0;
    // Pending bit lags the line by one cycle
    @(negedge core_clk_i);
    rdc(PND, 32'h0000_0000);
    warm_rst_i = 1'b1;
    @(negedge core_clk_i);
    warm_rst_i = 1'b0;
    rdc(SCR, 32'h0020_0000, 32'hffff_0000);
    chk(1'h1, mac_warm_rst_o);
    wr(RC, 32'h0000_0010);
    chk(1'h0, mac_warm_rst_o);
    chk(1'h0, bb_warm_rst_o);
    // Bit already stood high for one cycle inside the write task
    n = 1;
    while (core_warm_rst_o === 1'b1 && n < 100) begin
      n++;
      @(negedge core_clk_i);
    end
    chk(64, n);
    wr(RC, 32'h0000_0010);
    warm_rst_i = 1'b1;
    @(negedge core_clk_i);
    warm_rst_i = 1'b0;
    rdc(SCR, 32'h0001_0000, 32'hffff_0000);
    chk(1'h1, sleep_en_o);
    chk(1'h1, bb_warm_rst_o);
    complete_run();
  end
endmodule : tb_wlan_sleep_timer_control
